// ==== hdl/pmsc_pkg.sv ====
// Package: register map, field positions, reset values and carrier types of the power management block
package pmsc_pkg;

  // Register index on the plain register port
  localparam int             REG_ADDR_W      = 2;
  typedef logic [REG_ADDR_W-1:0] reg_addr_t;
  typedef logic [7:0]            reg_byte_t;

  localparam reg_addr_t      REG_ONE_IDX     = 2'h0;   // power_mgmt_status_control_one
  localparam reg_addr_t      REG_TWO_IDX     = 2'h1;   // power_mgmt_status_control_two
  localparam reg_addr_t      IRQ_STATUS_IDX  = 2'h2;   // Sticky event status, write one to clear
  localparam reg_addr_t      IRQ_MASK_IDX    = 2'h3;   // Event mask, same layout

  // Field positions of the first register
  localparam int             WARN_FLAG_BIT   = 7;
  localparam int             WARN_ACK_BIT    = 6;
  localparam int             WARN_IE_BIT     = 5;
  localparam int             DET_RE_BIT      = 4;
  localparam int             DET_SE_BIT      = 3;
  localparam int             DET_EN_BIT      = 2;
  localparam int             BG_EN_BIT       = 0;

  // Field positions of the second register
  localparam int             DET_VSEL_BIT    = 5;
  localparam int             WARN_VSEL_BIT   = 4;
  localparam int             PPD_FLAG_BIT    = 3;
  localparam int             PPD_ACK_BIT     = 2;
  localparam int             PPD_CTRL_BIT    = 0;

  // Reset images of the writable fields
  localparam reg_byte_t      REG_ONE_RESET   = 8'h1C;
  localparam reg_byte_t      REG_TWO_RESET   = 8'h00;

  // Event bits of the interrupt status and mask registers
  localparam int             EV_W            = 3;
  localparam int             EV_WARN_BIT     = 0;
  localparam int             EV_DETECT_BIT   = 1;
  localparam int             EV_PPD_BIT      = 2;
  typedef logic [EV_W-1:0]   ev_t;
  localparam ev_t            EV_NONE         = 3'h0;

  // Controls handed to the analog supply monitor and the stop logic
  typedef struct packed {
    logic       detect_on;       // Detect comparator powered
    logic       detect_reset;    // Request a device reset
    logic       detect_level;    // Detect trip level select
    logic [1:0] warn_level;      // Warning trip level code
    logic       bandgap_on;      // Bandgap reference buffer on
    logic       stop2_select;    // Next stop entry is partial power-down
  } analog_ctrl_t;

  localparam analog_ctrl_t   CTRL_RESET      = '{default: 1'b0};

endpackage : pmsc_pkg

// ==== hdl/power_mgmt_status_control.sv ====
// Power management status and control registers with supply monitor controls
//
// Overview of operation
// - Warning flag sets when supply below warning trip
// - Warning flag sticky until acknowledged
// - Acknowledge clears flag only without present warning
// - Interrupt request while flag and enable set
// - Detect reset enable forces reset on detect
// - Detect stop enable keeps detection running in stop
// - Detect enable powers detection, gates reset, stop
// - Bandgap buffer enable drives reference buffer
// - Write-once bits take only first write
// - Detect level select locked until power-on reset
// - Detect level select picks detect trip level
// - Warning select picks level within range
// - Level code maps detect:warning select bits
// - Partial power-down flag shows stop2 recovery
// - Writing acknowledge clears partial power-down flag
// - Control bit selects stop2 or stop3
`timescale 1ns/1ns

module power_mgmt_status_control (
  input  wire logic                  clk_i,
  input  wire logic                  reset_n_i,
  input  wire logic                  por_n_i,
  input  wire pmsc_pkg::reg_addr_t   addr_i,
  input  wire pmsc_pkg::reg_byte_t   wr_data_i,
  input  wire logic                  wr_i,
  input  wire logic                  rd_i,
  output logic [7:0]                 rd_data_o,
  input  wire logic                  warn_below_i,
  input  wire logic                  detect_below_i,
  input  wire logic                  stop_mode_i,
  input  wire logic                  stop2_recovered_i,
  output pmsc_pkg::analog_ctrl_t     ctrl_o,
  output logic                       irq_o
);
  import pmsc_pkg::*;

  // Whole state of the block except the power-on-only fields
  typedef struct packed {
    logic         warn_meta;     // First synchroniser stage, supply warning
    logic         warn_s;
    logic         det_meta;      // First synchroniser stage, supply detect
    logic         det_s;
    logic         det_prev;      // Edge memory for detect events
    logic         warn_flag;
    logic         warn_ie;
    logic         det_re;
    logic         det_se;
    logic         det_en;
    logic         bg_en;
    logic         one_written;   // First register already written once
    logic         warn_vsel;
    logic         ppd_flag;
    logic         ppd_ctrl;
    logic         two_written;   // Second register already written once
    ev_t          status;
    ev_t          mask;
    reg_byte_t    rd_data;
    logic         irq;
    analog_ctrl_t ctrl;
  } state_t;

  state_t st_q;
  state_t st_d;

  // Fields that survive every reset except power-on
  logic   det_vsel_q;
  logic   det_vsel_d;
  logic   vsel_written_q;
  logic   vsel_written_d;

  // Decoded bus strobes and derived detect and event terms
  logic   wr_one;
  logic   wr_two;
  logic   wr_stat;
  logic   wr_mask;
  logic   warn_ack;
  logic   ppd_ack;
  logic   detect_live;
  logic   detect_event;
  ev_t    ev_set;

  // A write-once field keeps its value once its register has been written
  function automatic logic write_once(input logic cur, input logic val, input logic written);
    write_once = written ? cur : val;
  endfunction : write_once

  // Read images; unimplemented positions stay zero
  function automatic reg_byte_t image_one(input state_t s);
    reg_byte_t v;
    v                = 8'h00;
    v[WARN_FLAG_BIT] = s.warn_flag;
    v[WARN_IE_BIT]   = s.warn_ie;
    v[DET_RE_BIT]    = s.det_re;
    v[DET_SE_BIT]    = s.det_se;
    v[DET_EN_BIT]    = s.det_en;
    v[BG_EN_BIT]     = s.bg_en;
    image_one        = v;
  endfunction : image_one

  function automatic reg_byte_t image_two(input state_t s, input logic dvsel);
    reg_byte_t v;
    v                = 8'h00;
    v[DET_VSEL_BIT]  = dvsel;
    v[WARN_VSEL_BIT] = s.warn_vsel;
    v[PPD_FLAG_BIT]  = s.ppd_flag;
    v[PPD_CTRL_BIT]  = s.ppd_ctrl;
    image_two        = v;
  endfunction : image_two

  // Strobe decode; acknowledge bits are actions, never stored
  always_comb begin
    wr_one   = wr_i && (addr_i == REG_ONE_IDX);
    wr_two   = wr_i && (addr_i == REG_TWO_IDX);
    wr_stat  = wr_i && (addr_i == IRQ_STATUS_IDX);
    wr_mask  = wr_i && (addr_i == IRQ_MASK_IDX);
    warn_ack = wr_one && wr_data_i[WARN_ACK_BIT];
    ppd_ack  = wr_two && wr_data_i[PPD_ACK_BIT];
  end

  // Detection runs only when enabled, and in stop only if allowed there
  always_comb begin
    detect_live  = st_q.det_en && (!stop_mode_i || st_q.det_se);
    detect_event = detect_live && st_q.det_s && !st_q.det_prev;
    ev_set                = EV_NONE;
    ev_set[EV_WARN_BIT]   = st_q.warn_s && !st_q.warn_flag;
    ev_set[EV_DETECT_BIT] = detect_event;
    ev_set[EV_PPD_BIT]    = stop2_recovered_i;
  end

  // Power-on-only field: later resets must not reopen it
  always_comb begin
    det_vsel_d     = det_vsel_q;
    vsel_written_d = vsel_written_q;
    if (wr_two) begin
      det_vsel_d     = write_once(det_vsel_q, wr_data_i[DET_VSEL_BIT], vsel_written_q);
      vsel_written_d = 1'b1;
    end
  end

  always_ff @(posedge clk_i or negedge por_n_i) begin
    if (!por_n_i) begin
      det_vsel_q     <= REG_TWO_RESET[DET_VSEL_BIT];
      vsel_written_q <= 1'b0;
    end else begin
      det_vsel_q     <= det_vsel_d;
      vsel_written_q <= vsel_written_d;
    end
  end

  // Next state of everything else
  always_comb begin
    st_d = st_q;

    // Supply comparators are asynchronous; two stages before any use
    st_d.warn_meta = warn_below_i;
    st_d.warn_s    = st_q.warn_meta;
    st_d.det_meta  = detect_below_i;
    st_d.det_s     = st_q.det_meta;
    st_d.det_prev  = detect_live && st_q.det_s;

    // A present condition beats an acknowledge in the same cycle
    if (warn_ack && !st_q.warn_s) begin
      st_d.warn_flag = 1'b0;
    end
    if (st_q.warn_s) begin
      st_d.warn_flag = 1'b1;
    end

    // First register: interrupt and bandgap enables always writable, detect bits once
    if (wr_one) begin
      st_d.warn_ie     = wr_data_i[WARN_IE_BIT];
      st_d.bg_en       = wr_data_i[BG_EN_BIT];
      st_d.det_re      = write_once(st_q.det_re, wr_data_i[DET_RE_BIT], st_q.one_written);
      st_d.det_se      = write_once(st_q.det_se, wr_data_i[DET_SE_BIT], st_q.one_written);
      st_d.det_en      = write_once(st_q.det_en, wr_data_i[DET_EN_BIT], st_q.one_written);
      st_d.one_written = 1'b1;
    end

    // Second register: stop mode select once, warning level always
    if (wr_two) begin
      st_d.warn_vsel   = wr_data_i[WARN_VSEL_BIT];
      st_d.ppd_ctrl    = write_once(st_q.ppd_ctrl, wr_data_i[PPD_CTRL_BIT], st_q.two_written);
      st_d.two_written = 1'b1;
    end

    // Recovery from partial power-down sets the flag over a clear
    if (ppd_ack) begin
      st_d.ppd_flag = 1'b0;
    end
    if (stop2_recovered_i) begin
      st_d.ppd_flag = 1'b1;
    end

    // Sticky events, write one to clear, a new event wins
    if (wr_stat) begin
      st_d.status = st_q.status & ~wr_data_i[EV_W-1:0];
    end
    st_d.status = st_d.status | ev_set;
    if (wr_mask) begin
      st_d.mask = wr_data_i[EV_W-1:0];
    end

    // Read data stands only in the cycle after the strobe
    st_d.rd_data = 8'h00;
    if (rd_i) begin
      case (addr_i)
        REG_ONE_IDX:    st_d.rd_data = image_one(st_q);
        REG_TWO_IDX:    st_d.rd_data = image_two(st_q, det_vsel_q);
        IRQ_STATUS_IDX: st_d.rd_data = {5'h00, st_q.status};
        IRQ_MASK_IDX:   st_d.rd_data = {5'h00, st_q.mask};
        default:        st_d.rd_data = 8'h00;
      endcase
    end

    // Warning enable alone is enough to request; other events go through the mask
    st_d.irq = (st_q.warn_ie && st_q.warn_flag) || (|(st_q.status & st_q.mask));

    // Controls to the analog side
    st_d.ctrl.detect_on    = detect_live;
    st_d.ctrl.detect_reset = detect_live && st_q.det_re && st_q.det_s;
    st_d.ctrl.detect_level = det_vsel_q;
    st_d.ctrl.warn_level   = {det_vsel_q, st_q.warn_vsel};
    st_d.ctrl.bandgap_on   = st_q.bg_en;
    st_d.ctrl.stop2_select = st_q.ppd_ctrl;
  end

  // Single register stage; reset loads constants only
  always_ff @(posedge clk_i or negedge reset_n_i) begin
    if (!reset_n_i) begin
      st_q             <= '0;
      st_q.warn_ie     <= REG_ONE_RESET[WARN_IE_BIT];
      st_q.det_re      <= REG_ONE_RESET[DET_RE_BIT];
      st_q.det_se      <= REG_ONE_RESET[DET_SE_BIT];
      st_q.det_en      <= REG_ONE_RESET[DET_EN_BIT];
      st_q.bg_en       <= REG_ONE_RESET[BG_EN_BIT];
      st_q.warn_vsel   <= REG_TWO_RESET[WARN_VSEL_BIT];
      st_q.ppd_ctrl    <= REG_TWO_RESET[PPD_CTRL_BIT];
      st_q.ctrl        <= CTRL_RESET;
    end else begin
      st_q <= st_d;
    end
  end

  // Outputs straight from flip-flops
  assign rd_data_o = st_q.rd_data;
  assign ctrl_o    = st_q.ctrl;
  assign irq_o     = st_q.irq;

  // Checks on the flags, write-once fields and controls
  warn_set_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    st_q.warn_s |=> st_q.warn_flag)
    else $error("warning flag not set while supply low");

  warn_sticky_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st_q.warn_flag && !warn_ack) |=> st_q.warn_flag)
    else $error("warning flag dropped without acknowledge");

  ack_blocked_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (warn_ack && st_q.warn_s) |=> st_q.warn_flag)
    else $error("acknowledge cleared flag during warning");

  ack_clears_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (warn_ack && !st_q.warn_s) |=> !st_q.warn_flag)
    else $error("acknowledge failed to clear warning flag");

  irq_follow_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st_q.warn_ie && st_q.warn_flag) |=> irq_o)
    else $error("no interrupt for enabled warning");

  det_reset_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (!st_q.det_en || !st_q.det_re) |=> !ctrl_o.detect_reset)
    else $error("reset request while detect reset disabled");

  stop_gate_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (stop_mode_i && !st_q.det_se) |=> !ctrl_o.detect_on)
    else $error("detection running in stop without stop enable");

  det_on_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (reset_n_i && st_q.det_en && !stop_mode_i) |=> ctrl_o.detect_on)
    else $error("detection off although enabled");

  bandgap_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ##1 ctrl_o.bandgap_on == $past(st_q.bg_en))
    else $error("bandgap buffer not following its enable");

  write_once_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_one && st_q.one_written) |=> $stable(st_q.det_en) && $stable(st_q.det_re) && $stable(st_q.det_se))
    else $error("write-once detect bits changed by a later write");

  por_lock_a: assert property (@(posedge clk_i) disable iff (!por_n_i)
    (wr_two && vsel_written_q) |=> $stable(det_vsel_q))
    else $error("detect level select changed after first write");

  level_map_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> ctrl_o.warn_level == {$past(det_vsel_q), $past(st_q.warn_vsel)})
    else $error("warning level code does not match selects");

  ppd_flag_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    stop2_recovered_i |=> st_q.ppd_flag ##1 (st_q.ppd_flag || $past(ppd_ack)))
    else $error("partial power-down flag not set on recovery");

  ppd_clear_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (ppd_ack && !stop2_recovered_i) |=> !st_q.ppd_flag)
    else $error("partial power-down flag not cleared");

  reserved_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (rd_i && addr_i == REG_TWO_IDX) |=> (rd_data_o[7:6] == 2'h0) && !rd_data_o[1])
    else $error("unimplemented bits read non-zero");

  // Read port, sticky events and remaining fields; a sampled reset_n_i in the antecedent
  // keeps the releasing edge, where the flops still hold reset, from starting an attempt
  rd_idle_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !rd_i |=> (rd_data_o == 8'h00))
    else $error("read data not zero outside a read");

  reserved_one_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (rd_i && addr_i == REG_ONE_IDX) |=> !rd_data_o[WARN_ACK_BIT] && !rd_data_o[1])
    else $error("acknowledge or unimplemented bit reads non-zero");

  ppd_once_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (wr_two && st_q.two_written) |=> $stable(st_q.ppd_ctrl))
    else $error("stop mode select changed by a later write");

  stop2_sel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> (ctrl_o.stop2_select == $past(st_q.ppd_ctrl)))
    else $error("stop mode select not passed on");

  det_level_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    reset_n_i |=> (ctrl_o.detect_level == $past(det_vsel_q)))
    else $error("detect level not following its select");

  warn_vsel_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_two |=> (st_q.warn_vsel == $past(wr_data_i[WARN_VSEL_BIT])))
    else $error("warning level select not written");

  det_reset_on_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (reset_n_i && st_q.det_en && st_q.det_re && st_q.det_s && !stop_mode_i) |=> ctrl_o.detect_reset)
    else $error("no reset request on enabled detect");

  stop_run_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (reset_n_i && st_q.det_en && st_q.det_se) |=> ctrl_o.detect_on)
    else $error("detection stopped although allowed in stop");

  det_ignored_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !st_q.det_en |=> !$rose(st_q.status[EV_DETECT_BIT]))
    else $error("detect event recorded while detection disabled");

  warn_event_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st_q.warn_s && !st_q.warn_flag) |=> st_q.status[EV_WARN_BIT])
    else $error("warning event not recorded");

  bg_write_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    wr_one |=> (st_q.bg_en == $past(wr_data_i[BG_EN_BIT])))
    else $error("bandgap enable not written");

  irq_quiet_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    ((!st_q.warn_ie || !st_q.warn_flag) && !(|(st_q.status & st_q.mask))) |=> !irq_o)
    else $error("interrupt without an enabled cause");

  ppd_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (st_q.ppd_flag && !ppd_ack) |=> st_q.ppd_flag)
    else $error("partial power-down flag dropped without acknowledge");

  ppd_event_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    stop2_recovered_i |=> st_q.status[EV_PPD_BIT])
    else $error("stop2 recovery not recorded");

  status_hold_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    !wr_stat |=> ((st_q.status & $past(st_q.status)) == $past(st_q.status)))
    else $error("status bit cleared without a write");

  irq_mask_a: assert property (@(posedge clk_i) disable iff (!reset_n_i)
    (|(st_q.status & st_q.mask)) |=> irq_o)
    else $error("no interrupt for unmasked status");

endmodule : power_mgmt_status_control

// ==== tb/test_power_mgmt_status_control.sv ====
// Self-checking bench for the power management status and control registers
`timescale 1ns/1ns

module test_power_mgmt_status_control;
  import pmsc_pkg::*;

  logic         clk_i;
  logic         reset_n_i;
  logic         por_n_i;
  reg_addr_t    addr_i;
  reg_byte_t    wr_data_i;
  logic         wr_i;
  logic         rd_i;
  logic [7:0]   rd_data_o;
  logic         warn_below_i;
  logic         detect_below_i;
  logic         stop_mode_i;
  logic         stop2_recovered_i;
  analog_ctrl_t ctrl_o;
  logic         irq_o;
  int           err_count;
  int           compares;
  reg_byte_t    d1;
  reg_byte_t    d2;
  reg_byte_t    two_q;

  power_mgmt_status_control i_power_mgmt_status_control (
    .clk_i             (clk_i),
    .reset_n_i         (reset_n_i),
    .por_n_i           (por_n_i),
    .addr_i            (addr_i),
    .wr_data_i         (wr_data_i),
    .wr_i              (wr_i),
    .rd_i              (rd_i),
    .rd_data_o         (rd_data_o),
    .warn_below_i      (warn_below_i),
    .detect_below_i    (detect_below_i),
    .stop_mode_i       (stop_mode_i),
    .stop2_recovered_i (stop2_recovered_i),
    .ctrl_o            (ctrl_o),
    .irq_o             (irq_o)
  );

  // Free-running 125 MHz clock
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end

  task automatic finish_test;
    $display("Comparisons %0d, mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask : finish_test

  task automatic chk8(input string what, input logic [7:0] exp, input logic [7:0] got);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask : chk8

  task automatic idle(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask : idle

  // One-cycle write strobe, released at the next edge
  task automatic wr(input reg_addr_t a, input reg_byte_t d);
    @(posedge clk_i);
    wr_i      <= 1'b1;
    addr_i    <= a;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_i      <= 1'b0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input string what, input reg_addr_t a, input reg_byte_t exp);
    @(posedge clk_i);
    rd_i   <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_i   <= 1'b0;
    #1;
    chk8(what, exp, rd_data_o);
  endtask : rd_chk

  // Both resets together model power-up; reset alone keeps the power-on lock
  task automatic do_reset(input logic with_por);
    @(posedge clk_i);
    reset_n_i <= 1'b0;
    por_n_i   <= ~with_por;
    repeat (10) @(posedge clk_i);
    reset_n_i <= 1'b1;
    por_n_i   <= 1'b1;
  endtask : do_reset

  // Hang guard, far beyond the few hundred cycles the sequence needs
  initial begin
    #200000;
    err_count++;
    finish_test();
  end

  initial begin
    err_count = 0;
    compares = 0;
    reset_n_i = 1'b0;
    por_n_i = 1'b0;
    addr_i = 2'h0;
    wr_data_i = 8'h00;
    wr_i = 1'b0;
    rd_i = 1'b0;
    warn_below_i = 1'b0;
    detect_below_i = 1'b0;
    stop_mode_i = 1'b0;
    stop2_recovered_i = 1'b0;
    void'($urandom(32'h32D3));
    do_reset(1'b1);
    rd_chk("reg one reset", REG_ONE_IDX, REG_ONE_RESET);
    rd_chk("reg two reset", REG_TWO_IDX, REG_TWO_RESET);
    rd_chk("status reset", IRQ_STATUS_IDX, 8'h00);
    // Random first and second writes: write-once fields keep the first value
    d1 = 8'($urandom());
    d2 = 8'($urandom());
    wr(REG_ONE_IDX, d1);
    wr(REG_ONE_IDX, d2);
    rd_chk("reg one locked", REG_ONE_IDX, (d2 & 8'h21) | (d1 & 8'h1C));
    idle(2);
    chk8("bandgap", {7'h00, d2[0]}, {7'h00, ctrl_o.bandgap_on});
    chk8("detect on", {7'h00, d1[2]}, {7'h00, ctrl_o.detect_on});
    chk8("irq idle", 8'h00, {7'h00, irq_o});
    d1 = 8'($urandom());
    d2 = 8'($urandom());
    wr(REG_TWO_IDX, d1);
    wr(REG_TWO_IDX, d2);
    two_q = (d2 & 8'h10) | (d1 & 8'h21);
    rd_chk("reg two locked", REG_TWO_IDX, two_q);
    idle(2);
    chk8("levels", {6'h00, d1[5], d2[4]}, {6'h00, ctrl_o.warn_level});
    chk8("stop2 sel", {7'h00, d1[0]}, {7'h00, ctrl_o.stop2_select});
    // Supply already low across a system reset; power-on lock must survive
    warn_below_i <= 1'b1;
    do_reset(1'b0);
    idle(4);
    rd_chk("flag after reset", REG_ONE_IDX, 8'h9C);
    chk8("irq polled", 8'h00, {7'h00, irq_o});
    rd_chk("detect sel kept", REG_TWO_IDX, d1 & 8'h20);
    d2 = 8'($urandom());
    wr(REG_TWO_IDX, d2 & 8'hFB);
    two_q = (d2 & 8'h11) | (d1 & 8'h20);
    rd_chk("reg two reopened", REG_TWO_IDX, two_q);
    // Detect event with reset image: detection, reset request, kept in stop
    detect_below_i <= 1'b1;
    idle(5);
    chk8("detect reset", 8'h01, {7'h00, ctrl_o.detect_reset});
    stop_mode_i <= 1'b1;
    idle(3);
    chk8("on in stop", 8'h01, {7'h00, ctrl_o.detect_on});
    stop_mode_i <= 1'b0;
    detect_below_i <= 1'b0;
    rd_chk("status events", IRQ_STATUS_IDX, 8'h03);
    // Acknowledge while still low must not clear; interrupt follows flag
    wr(REG_ONE_IDX, 8'h60);
    rd_chk("ack refused", REG_ONE_IDX, 8'hA0);
    idle(2);
    chk8("warn irq", 8'h01, {7'h00, irq_o});
    chk8("detect off", 8'h00, {7'h00, ctrl_o.detect_on});
    wr(IRQ_STATUS_IDX, 8'h07);
    warn_below_i <= 1'b0;
    idle(4);
    rd_chk("flag sticky", REG_ONE_IDX, 8'hA0);
    wr(REG_ONE_IDX, 8'hC2);
    rd_chk("ack clears", REG_ONE_IDX, 8'h00);
    idle(2);
    chk8("irq dropped", 8'h00, {7'h00, irq_o});
    // Stop2 recovery: masked status, then unmasked, then cleared
    @(posedge clk_i);
    stop2_recovered_i <= 1'b1;
    @(posedge clk_i);
    stop2_recovered_i <= 1'b0;
    idle(2);
    rd_chk("ppd flag", REG_TWO_IDX, two_q | 8'h08);
    rd_chk("ppd status", IRQ_STATUS_IDX, 8'h04);
    chk8("masked irq", 8'h00, {7'h00, irq_o});
    wr(IRQ_MASK_IDX, 8'h04);
    idle(2);
    chk8("unmasked irq", 8'h01, {7'h00, irq_o});
    wr(REG_TWO_IDX, (two_q & 8'h10) | 8'h0C);
    rd_chk("ppd ack", REG_TWO_IDX, two_q);
    wr(IRQ_STATUS_IDX, 8'h04);
    idle(2);
    chk8("cleared irq", 8'h00, {7'h00, irq_o});
    // Every detect:warning select code after a fresh power-up
    for (int i = 0; i < 4; i++) begin
      do_reset(1'b1);
      wr(REG_TWO_IDX, {2'h0, 2'(i), 4'h0});
      idle(2);
      chk8("level code", 8'(i), {6'h00, ctrl_o.warn_level});
      chk8("detect level", 8'(i / 2), {7'h00, ctrl_o.detect_level});
      // Detection enabled, stop enable alternating: only an allowed stop keeps it on
      wr(REG_ONE_IDX, {4'h0, 1'(i), 3'h4});
      stop_mode_i <= 1'b1;
      idle(2);
      chk8("stop gate", 8'(i % 2), {7'h00, ctrl_o.detect_on});
      stop_mode_i <= 1'b0;
    end
    finish_test();
  end

endmodule : test_power_mgmt_status_control
